// ---- rtl/irq_cfg_pkg.sv ----
package irq_cfg_pkg;

    // =====================================================================
    // Sizes
    // =====================================================================
    localparam int SRC_COUNT = 5;
    localparam int REG_COUNT = 5;

    // =====================================================================
    // Register indexes
    // =====================================================================
    localparam logic [2:0] IDX_ENABLE   = 3'h0;
    localparam logic [2:0] IDX_PRIORITY = 3'h1;
    localparam logic [2:0] IDX_STATUS   = 3'h2;
    localparam logic [2:0] IDX_ACCUM    = 3'h3;
    localparam logic [2:0] IDX_BREG     = 3'h4;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int GLOBAL_EN_POS = 7;
    localparam int CARRY_POS     = 7;
    localparam logic [2:0] SRC_EXT0   = 3'h0;
    localparam logic [2:0] SRC_TIMER0 = 3'h1;
    localparam logic [2:0] SRC_EXT1   = 3'h2;
    localparam logic [2:0] SRC_TIMER1 = 3'h3;
    localparam logic [2:0] SRC_UART   = 3'h4;

    // =====================================================================
    // Implemented bits and values after reset
    // =====================================================================
    localparam logic [7:0] ENABLE_IMPL_MASK   = 8'h9F;
    localparam logic [7:0] PRIORITY_IMPL_MASK = 8'h1F;
    localparam logic [7:0] FULL_MASK          = 8'hFF;
    localparam logic [7:0] ENABLE_RESET       = 8'h00;
    localparam logic [7:0] PRIORITY_RESET     = 8'h00;
    localparam logic [7:0] STATUS_RESET       = 8'h00;
    localparam logic [7:0] ACCUM_RESET        = 8'h00;
    localparam logic [7:0] BREG_RESET         = 8'h00;

    // =====================================================================
    // Types
    // =====================================================================
    typedef enum logic [1:0] {BYTE_MOVE, BYTE_AND, BYTE_OR, BYTE_XOR} byte_op_t;

    typedef struct packed {
        logic [2:0] index;
        logic [2:0] pos;
    } bit_addr_t;

    typedef struct packed {
        logic       valid;
        logic       high;
        logic [2:0] source;
    } irq_req_t;

endpackage

// ---- rtl/interrupt_enable_priority_regs.sv ----
`timescale 1ns/1ns
module interrupt_enable_priority_regs
    import irq_cfg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       byteWrite,
    input  wire logic [2:0] byteAddr,
    input  wire logic [7:0] byteData,
    input  wire byte_op_t   byteOp,
    input  wire logic       bitWrite,
    input  wire bit_addr_t  bitAddr,
    input  wire logic       bitData,
    input  wire logic [2:0] readAddr,
    input  wire bit_addr_t  bitReadAddr,
    input  wire logic       carryWrite,
    input  wire logic       carryIn,
    input  wire logic       ext0Flag,
    input  wire logic       timer0Flag,
    input  wire logic       ext1Flag,
    input  wire logic       timer1Flag,
    input  wire logic       uartTxDoneFlag,
    input  wire logic       uartRxDoneFlag,
    output logic      [7:0] readData,
    output logic            bitReadData,
    output logic            carryFlag,
    output irq_req_t        irqRequest
);

    // =====================================================================
    // Helpers
    // =====================================================================
    function automatic logic [7:0] implMask(input logic [2:0] idx);
        case (idx)
            IDX_ENABLE:   implMask = ENABLE_IMPL_MASK;
            IDX_PRIORITY: implMask = PRIORITY_IMPL_MASK;
            default:      implMask = FULL_MASK;
        endcase
    endfunction

    function automatic logic [7:0] resetValue(input logic [2:0] idx);
        case (idx)
            IDX_ENABLE:   resetValue = ENABLE_RESET;
            IDX_PRIORITY: resetValue = PRIORITY_RESET;
            IDX_STATUS:   resetValue = STATUS_RESET;
            IDX_ACCUM:    resetValue = ACCUM_RESET;
            default:      resetValue = BREG_RESET;
        endcase
    endfunction

    function automatic logic [7:0] applyOp(
        input logic [7:0] old,
        input logic [7:0] data,
        input byte_op_t   op
    );
        case (op)
            BYTE_AND: applyOp = old & data;
            BYTE_OR:  applyOp = old | data;
            BYTE_XOR: applyOp = old ^ data;
            default:  applyOp = data;
        endcase
    endfunction

    function automatic logic [2:0] firstSet(input logic [SRC_COUNT-1:0] vec);
        firstSet = 3'h0;
        for (int i = SRC_COUNT - 1; i >= 0; i--) begin
            if (vec[i]) begin
                firstSet = 3'(i);
            end
        end
    endfunction

    // =====================================================================
    // Register file
    // =====================================================================
    logic [7:0]           sfr      [REG_COUNT];
    logic [7:0]           next_sfr [REG_COUNT];
    logic [SRC_COUNT-1:0] srcFlags;
    logic [SRC_COUNT-1:0] srcEnable;
    logic [SRC_COUNT-1:0] srcHigh;
    logic [SRC_COUNT-1:0] reqHigh;
    logic [SRC_COUNT-1:0] reqLow;
    logic                 globalIrqEnable;
    logic                 anyHigh;
    logic                 anyLow;
    logic [7:0]           statusOpResult;
    logic [7:0]           statusAfterCarry;

    genvar r;
    generate
        for (r = 0; r < REG_COUNT; r++) begin : g_reg
            localparam logic [2:0] IDX = 3'(r);

            // Core carry first, then byte access, then bit access
            always_comb begin
                next_sfr[r] = sfr[r];
                if (IDX == IDX_STATUS && carryWrite) begin
                    next_sfr[r][CARRY_POS] = carryIn;
                end
                if (byteWrite && byteAddr == IDX) begin
                    next_sfr[r] = applyOp(next_sfr[r], byteData, byteOp);
                end
                if (bitWrite && bitAddr.index == IDX) begin
                    next_sfr[r][bitAddr.pos] = bitData;
                end
                // Unimplemented bits stay zero
                next_sfr[r] = next_sfr[r] & implMask(IDX);
            end

            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    sfr[r] <= resetValue(IDX);
                end else begin
                    sfr[r] <= next_sfr[r];
                end
            end
        end
    endgenerate

    // Status value a same-cycle byte operation works on
    always_comb begin
        statusAfterCarry = sfr[IDX_STATUS];
        if (carryWrite) begin
            statusAfterCarry[CARRY_POS] = carryIn;
        end
    end
    assign statusOpResult = applyOp(statusAfterCarry, byteData, byteOp);
    assign carryFlag      = sfr[IDX_STATUS][CARRY_POS];

    // =====================================================================
    // Read port
    // =====================================================================
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            readData <= 8'h00;
        end else if (readAddr < 3'(REG_COUNT)) begin
            readData <= sfr[readAddr];
        end else begin
            readData <= 8'h00;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bitReadData <= 1'b0;
        end else if (bitReadAddr.index < 3'(REG_COUNT)) begin
            bitReadData <= sfr[bitReadAddr.index][bitReadAddr.pos];
        end else begin
            bitReadData <= 1'b0;
        end
    end

    // =====================================================================
    // Request gating and arbitration
    // =====================================================================
    assign srcFlags = {uartTxDoneFlag | uartRxDoneFlag, timer1Flag, ext1Flag,
                       timer0Flag, ext0Flag};
    assign srcEnable       = sfr[IDX_ENABLE][SRC_COUNT-1:0];
    assign srcHigh         = sfr[IDX_PRIORITY][SRC_COUNT-1:0];
    assign globalIrqEnable = sfr[IDX_ENABLE][GLOBAL_EN_POS];

    genvar s;
    generate
        for (s = 0; s < SRC_COUNT; s++) begin : g_src
            assign reqHigh[s] = srcFlags[s] & srcEnable[s] & globalIrqEnable & srcHigh[s];
            assign reqLow[s]  = srcFlags[s] & srcEnable[s] & globalIrqEnable & ~srcHigh[s];
        end
    endgenerate

    assign anyHigh = |reqHigh;
    assign anyLow  = |reqLow;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irqRequest <= '0;
        end else if (anyHigh) begin
            irqRequest <= '{valid: 1'b1, high: 1'b1, source: firstSet(reqHigh)};
        end else if (anyLow) begin
            irqRequest <= '{valid: 1'b1, high: 1'b0, source: firstSet(reqLow)};
        end else begin
            irqRequest <= '0;
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    sequence gatedRequest;
        (anyHigh || anyLow) ##1 irqRequest.valid;
    endsequence

    sequence highChosen;
        anyHigh ##1 (irqRequest.valid && irqRequest.high);
    endsequence

    chk_global_block: assert property (@(posedge clk) disable iff (reset)
        !globalIrqEnable |=> !irqRequest.valid)
        else $error("request raised while global enable clear");

    chk_uart_gate: assert property (@(posedge clk) disable iff (reset)
        irqRequest.valid && irqRequest.source == SRC_UART
        |-> $past(srcEnable[SRC_UART] && (uartTxDoneFlag || uartRxDoneFlag)))
        else $error("serial request without enable or flag");

    chk_timer1_gate: assert property (@(posedge clk) disable iff (reset)
        irqRequest.valid && irqRequest.source == SRC_TIMER1
        |-> $past(srcEnable[SRC_TIMER1] && timer1Flag))
        else $error("timer 1 request without enable or flag");

    chk_ext1_gate: assert property (@(posedge clk) disable iff (reset)
        irqRequest.valid && irqRequest.source == SRC_EXT1
        |-> $past(srcEnable[SRC_EXT1] && ext1Flag))
        else $error("pin 1 request without enable or flag");

    chk_timer0_gate: assert property (@(posedge clk) disable iff (reset)
        irqRequest.valid && irqRequest.source == SRC_TIMER0
        |-> $past(srcEnable[SRC_TIMER0] && timer0Flag))
        else $error("timer 0 request without enable or flag");

    chk_ext0_gate: assert property (@(posedge clk) disable iff (reset)
        irqRequest.valid && irqRequest.source == SRC_EXT0
        |-> $past(srcEnable[SRC_EXT0] && ext0Flag))
        else $error("pin 0 request without enable or flag");

    chk_priority_level: assert property (@(posedge clk) disable iff (reset)
        irqRequest.valid
        |-> irqRequest.high == |($past(srcHigh) & (5'h01 << irqRequest.source)))
        else $error("request level differs from priority bit");

    chk_high_first: assert property (@(posedge clk) disable iff (reset)
        anyHigh |-> highChosen)
        else $error("low request taken while high pending");

    chk_request_timing: assert property (@(posedge clk) disable iff (reset)
        (anyHigh || anyLow) |-> gatedRequest)
        else $error("gated request not presented next cycle");

    chk_no_spurious: assert property (@(posedge clk) disable iff (reset)
        !(anyHigh || anyLow) |=> !irqRequest.valid)
        else $error("request presented with nothing pending");

    chk_accum_bit: assert property (@(posedge clk) disable iff (reset)
        bitWrite && bitAddr.index == IDX_ACCUM
        |=> sfr[IDX_ACCUM][$past(bitAddr.pos)] == $past(bitData))
        else $error("accumulator bit write lost");

    chk_breg_bit: assert property (@(posedge clk) disable iff (reset)
        bitWrite && bitAddr.index == IDX_BREG
        |=> sfr[IDX_BREG][$past(bitAddr.pos)] == $past(bitData))
        else $error("B register bit write lost");

    chk_carry_byte: assert property (@(posedge clk) disable iff (reset)
        byteWrite && byteAddr == IDX_STATUS && !(bitWrite && bitAddr.index == IDX_STATUS)
        |=> carryFlag == $past(statusOpResult[CARRY_POS]))
        else $error("status byte operation did not update carry");

    chk_reserved_zero: assert property (@(posedge clk) disable iff (reset)
        (sfr[IDX_ENABLE] & ~ENABLE_IMPL_MASK) == 8'h00
        && (sfr[IDX_PRIORITY] & ~PRIORITY_IMPL_MASK) == 8'h00)
        else $error("unimplemented bit holds a one");

    chk_timer1_level: assert property (@(posedge clk) disable iff (reset)
        irqRequest.valid && irqRequest.source == SRC_TIMER1
        |-> irqRequest.high == $past(srcHigh[SRC_TIMER1]))
        else $error("timer 1 request level differs from priority bit");

    chk_ext1_level: assert property (@(posedge clk) disable iff (reset)
        irqRequest.valid && irqRequest.source == SRC_EXT1
        |-> irqRequest.high == $past(srcHigh[SRC_EXT1]))
        else $error("pin 1 request level differs from priority bit");

    chk_timer0_level: assert property (@(posedge clk) disable iff (reset)
        irqRequest.valid && irqRequest.source == SRC_TIMER0
        |-> irqRequest.high == $past(srcHigh[SRC_TIMER0]))
        else $error("timer 0 request level differs from priority bit");

    chk_ext0_level: assert property (@(posedge clk) disable iff (reset)
        irqRequest.valid && irqRequest.source == SRC_EXT0
        |-> irqRequest.high == $past(srcHigh[SRC_EXT0]))
        else $error("pin 0 request level differs from priority bit");

    chk_source_range: assert property (@(posedge clk) disable iff (reset)
        irqRequest.valid |-> irqRequest.source < 3'(SRC_COUNT))
        else $error("request names a source outside the five");

    chk_carry_core: assert property (@(posedge clk) disable iff (reset)
        carryWrite && !(byteWrite && byteAddr == IDX_STATUS)
        && !(bitWrite && bitAddr.index == IDX_STATUS && bitAddr.pos == 3'(CARRY_POS))
        |=> carryFlag == $past(carryIn))
        else $error("core carry update lost");

endmodule

// ---- test/irq_core_model.sv ----
`timescale 1ns/1ns
module irq_core_model
    import irq_cfg_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     reset,
    input  wire irq_req_t irqRequest,
    output logic          badSource,
    output int            takenCnt
);
    // =====================================
    // Core side acceptance of requests
    // =====================================
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            takenCnt  <= 0;
            badSource <= 1'b0;
        end else if (irqRequest.valid === 1'b1) begin
            takenCnt <= takenCnt + 1;
            if (irqRequest.source > SRC_UART) begin
                badSource <= 1'b1;
            end
        end
    end
endmodule

// ---- test/interrupt_enable_priority_regs_tb.sv ----
`timescale 1ns/1ns
module interrupt_enable_priority_regs_tb;
    import irq_cfg_pkg::*;
    logic       clk, reset, byteWrite, bitWrite, bitData, carryWrite, carryIn;
    logic [2:0] byteAddr, readAddr, src;
    logic [7:0] byteData, readData;
    logic [5:0] flags;
    logic       bitReadData, carryFlag, badSource;
    byte_op_t   byteOp;
    bit_addr_t  bitAddr, bitReadAddr;
    irq_req_t   irqRequest;
    int         takenCnt, errorCnt, nTests;

    interrupt_enable_priority_regs uut (.clk(clk), .reset(reset), .byteWrite(byteWrite),
        .byteAddr(byteAddr), .byteData(byteData), .byteOp(byteOp), .bitWrite(bitWrite),
        .bitAddr(bitAddr), .bitData(bitData), .readAddr(readAddr),
        .bitReadAddr(bitReadAddr), .carryWrite(carryWrite), .carryIn(carryIn),
        .ext0Flag(flags[0]), .timer0Flag(flags[1]), .ext1Flag(flags[2]),
        .timer1Flag(flags[3]), .uartTxDoneFlag(flags[4]), .uartRxDoneFlag(flags[5]),
        .readData(readData), .bitReadData(bitReadData), .carryFlag(carryFlag),
        .irqRequest(irqRequest));
    irq_core_model core (.clk(clk), .reset(reset), .irqRequest(irqRequest),
        .badSource(badSource), .takenCnt(takenCnt));

    // =====================================
    // Access tasks
    // =====================================
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input byte_op_t op);
        byteAddr = a;
        byteData = d;
        byteOp = op;
        byteWrite = 1'b1;
        @(negedge clk);
        byteWrite = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        readAddr = a;
        @(negedge clk);
        check(readData, exp);
    endtask
    task automatic bitw(input logic [2:0] idx, input logic [2:0] pos, input logic v);
        bitAddr = '{idx, pos};
        bitData = v;
        bitWrite = 1'b1;
        @(negedge clk);
        bitWrite = 1'b0;
    endtask
    task automatic brd(input logic [2:0] idx, input logic [2:0] pos, input logic exp);
        bitReadAddr = '{idx, pos};
        @(negedge clk);
        check({7'h00, bitReadData}, {7'h00, exp});
    endtask
    task automatic req(input logic [5:0] f, input irq_req_t exp);
        flags = f;
        @(negedge clk);
        check({3'h0, irqRequest}, {3'h0, exp});
        flags = 6'h00;
        @(negedge clk);
    endtask
    task automatic wrapUp;
        $display("comparisons %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // =====================================
    // Clock, watchdog and sequence
    // =====================================
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #2000000;
        errorCnt++;
        wrapUp;
    end
    initial begin
        {reset, byteWrite, bitWrite, bitData, carryWrite, carryIn} = 6'h20;
        {byteAddr, readAddr, byteData, flags} = '0;
        byteOp = BYTE_MOVE;
        bitAddr = '0;
        bitReadAddr = '0;
        errorCnt = 0;
        nTests = 0;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00);
        $display("test reset done");
        wr(IDX_ENABLE, 8'h9F, BYTE_MOVE);
        rd(IDX_ENABLE, 8'h9F);
        wr(IDX_PRIORITY, 8'h1F, BYTE_MOVE);
        rd(IDX_PRIORITY, 8'h1F);
        for (int i = 0; i < 5; i++) begin
            bitw(IDX_ENABLE, i[2:0], 1'b0);
            brd(IDX_ENABLE, i[2:0], 1'b0);
            bitw(IDX_PRIORITY, i[2:0], 1'b0);
            brd(IDX_PRIORITY, i[2:0], 1'b0);
        end
        rd(IDX_ENABLE, 8'h80);
        wr(IDX_ENABLE, 8'h1F, BYTE_OR);
        wr(IDX_ENABLE, 8'h0F, BYTE_AND);
        wr(IDX_ENABLE, 8'h14, BYTE_XOR);
        rd(IDX_ENABLE, 8'h1B);
        $display("test registers done");
        for (int s = 0; s < 6; s++) begin
            src = (s == 5) ? SRC_UART : s[2:0];
            wr(IDX_ENABLE, 8'h80 | (8'h01 << src), BYTE_MOVE);
            wr(IDX_PRIORITY, 8'h00, BYTE_MOVE);
            req(6'h01 << s, '{1'b1, 1'b0, src});
            bitw(IDX_PRIORITY, src, 1'b1);
            req(6'h01 << s, '{1'b1, 1'b1, src});
            bitw(IDX_ENABLE, 3'h7, 1'b0);
            req(6'h3F, '0);
            wr(IDX_ENABLE, 8'h9F ^ (8'h01 << src), BYTE_MOVE);
            req(6'h01 << s, '0);
        end
        $display("test gating done");
        wr(IDX_ENABLE, 8'h9F, BYTE_MOVE);
        wr(IDX_PRIORITY, 8'h00, BYTE_MOVE);
        req(6'h3F, '{1'b1, 1'b0, SRC_EXT0});
        wr(IDX_PRIORITY, 8'h18, BYTE_MOVE);
        req(6'h3F, '{1'b1, 1'b1, SRC_TIMER1});
        wr(IDX_PRIORITY, 8'h12, BYTE_MOVE);
        req(6'h20, '{1'b1, 1'b1, SRC_UART});
        req(6'h3F, '{1'b1, 1'b1, SRC_TIMER0});
        check({7'h00, badSource}, 8'h00);
        check(8'(takenCnt), 8'h10);
        $display("test priority done");
        for (int i = 0; i < 16; i++) begin
            bitw((i < 8) ? IDX_ACCUM : IDX_BREG, i[2:0], 1'b1);
            brd((i < 8) ? IDX_ACCUM : IDX_BREG, i[2:0], 1'b1);
        end
        bitw(IDX_BREG, 3'h5, 1'b0);
        rd(IDX_ACCUM, 8'hFF);
        rd(IDX_BREG, 8'hDF);
        $display("test bit flags done");
        wr(IDX_STATUS, 8'h80, BYTE_MOVE);
        check({7'h00, carryFlag}, 8'h01);
        wr(IDX_STATUS, 8'h81, BYTE_XOR);
        check({7'h00, carryFlag}, 8'h00);
        wr(IDX_STATUS, 8'hF0, BYTE_OR);
        check({7'h00, carryFlag}, 8'h01);
        wr(IDX_STATUS, 8'h7F, BYTE_AND);
        check({7'h00, carryFlag}, 8'h00);
        carryIn = 1'b1;
        carryWrite = 1'b1;
        @(negedge clk);
        carryWrite = 1'b0;
        check({7'h00, carryFlag}, 8'h01);
        rd(IDX_STATUS, 8'hF1);
        $display("test carry done");
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        rd(IDX_ENABLE, 8'h00);
        rd(IDX_PRIORITY, 8'h00);
        check({7'h00, carryFlag}, 8'h00);
        $display("test second reset done");
        wrapUp;
    end
endmodule
